// >>> rtl/pcsr_pkg.sv
package pcsr_pkg;

   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [15:0] ADDR_MASTER_DATA_OUT_PAD = 16'hF7A0;
   localparam logic [15:0] ADDR_MP6_PAD             = 16'hF7A1;
   localparam logic [15:0] ADDR_MP7_PAD             = 16'hF7A2;
   localparam logic [15:0] ADDR_CLOCK_OUT_PAD       = 16'hF7A3;
   localparam logic [15:0] ADDR_SOFT_RESET          = 16'hF890;
   localparam logic [15:0] ADDR_PLL_FIRST           = 16'hF000;
   localparam logic [15:0] ADDR_PLL_LAST            = 16'hF006;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int DRIVE_LSB = 0;
   localparam int SLEW_LSB  = 2;
   localparam int PULL_BIT  = 4;
   localparam int SRST_BIT  = 0;
   localparam logic [15:0] PAD_FIELD_MASK  = 16'h001F;
   localparam logic [15:0] SRST_FIELD_MASK = 16'h0001;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [15:0] RST_MASTER_DATA_OUT_PAD = 16'h0018;
   localparam logic [15:0] RST_MP6_PAD             = 16'h0018;
   localparam logic [15:0] RST_MP7_PAD             = 16'h0018;
   localparam logic [15:0] RST_CLOCK_OUT_PAD       = 16'h0008;
   localparam logic [15:0] RST_SOFT_RESET          = 16'h0001;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      SLAVE_I2C = 2'b00,
      SLAVE_SPI = 2'b01
   } pcsr_slave_mode_t;

   // one pad's controls as seen by the pad ring
   typedef struct packed {
      logic       pull_en;
      logic [1:0] slew;
      logic [1:0] drive;
   } pcsr_pad_cfg_t;

   // register access request from the slave control port
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } pcsr_req_t;

endpackage : pcsr_pkg

// >>> rtl/pcsr_pad_reg.sv
`timescale 1ns/1ns
// one pad configuration register, loaded with RESET_VALUE by hard or soft reset
module pcsr_pad_reg
   import pcsr_pkg::*;
#(
   parameter logic [15:0] RESET_VALUE = RST_MP6_PAD
) (
   // clock and reset
   input  wire logic          i_clock,
   input  wire logic          i_sys_rst,
   input  wire logic          i_soft_rst,
   // write port
   input  wire logic          i_wr,
   input  wire logic [15:0]   i_wdata,
   // register contents
   output pcsr_pad_cfg_t      o_cfg,
   output logic [15:0]        o_rdata
);

   typedef struct packed {
      logic [4:0] fields;
   } pcsr_pad_state_t;

   pcsr_pad_state_t state_ff;
   pcsr_pad_state_t nxt_state;

   // only bits 4:0 are stored, so a default with reserved bits set cannot be held
   if ((RESET_VALUE & ~PAD_FIELD_MASK) != 16'h0000) begin : g_reset_value_bad
      $error("pad register default sets reserved bits");
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nxt_state = state_ff;
      if (i_soft_rst) begin
         nxt_state.fields = RESET_VALUE[4:0];
      end else if (i_wr) begin
         nxt_state.fields = i_wdata[4:0];
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_ff <= '{fields: RESET_VALUE[4:0]};
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_cfg.pull_en = state_ff.fields[PULL_BIT];
   assign o_cfg.slew    = state_ff.fields[SLEW_LSB +: 2];
   assign o_cfg.drive   = state_ff.fields[DRIVE_LSB +: 2];
   assign o_rdata       = {11'h000, state_ff.fields};

endmodule : pcsr_pad_reg

// >>> rtl/pcsr_regs.sv
`timescale 1ns/1ns
// Notes on behaviour
// - each pad register keeps drive in bits 1:0 and slew in bits 3:2, bits 15:5 reserved.
// - the master data output pad register resets to 0x0018 and bit 4 enables its pull-up.
// - the pin six pad register resets to 0x0018 and bit 4 enables its pull-down.
// - the pin seven pad register resets to 0x0018 and bit 4 enables its pull-down.
// - the clock output pad register resets to 0x0008 and bit 4 enables its pull-down.
// - soft reset bit 0 is active low, the register resets to 0x0001.
// - while soft reset is held the four pad registers return to default; PLL ones and the slave mode do not.
// - the slave ports stay usable in soft reset and PLL writes are still accepted.
// - a chosen SPI slave mode survives soft reset and only hardware reset returns to I2C.
module pcsr_regs
   import pcsr_pkg::*;
(
   // clock and reset
   input  wire logic          i_clock,
   input  wire logic          i_sys_rst,
   // register access from the slave control port
   input  pcsr_req_t          i_req,
   output logic [15:0]        o_rdata,
   output logic               o_rvalid,
   output logic               o_hit,
   // slave port mode select
   input  wire logic          i_spi_select,
   output pcsr_slave_mode_t   o_slave_mode,
   // pad controls
   output pcsr_pad_cfg_t      o_master_data_out_pad,
   output pcsr_pad_cfg_t      o_multipurpose_pin_six_pad,
   output pcsr_pad_cfg_t      o_multipurpose_pin_seven_pad,
   output pcsr_pad_cfg_t      o_clock_output_pin_pad,
   // soft reset to the rest of the core and pll write forwarding
   output logic               o_soft_rst,
   output logic               o_pll_wr
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic             srst_n;
      pcsr_slave_mode_t mode;
      logic [15:0]      rdata;
      logic             rvalid;
   } pcsr_state_t;

   pcsr_state_t   state_ff;
   pcsr_state_t   nxt_state;

   logic [3:0]    pad_wr;
   logic [15:0]   pad_rdata [4];
   logic          soft_rst;
   logic          pll_hit;

   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   // o_hit decodes the four pad registers as one address range
   if (ADDR_CLOCK_OUT_PAD - ADDR_MASTER_DATA_OUT_PAD != 16'h0003) begin : g_pad_range_bad
      $error("pad registers must sit at four consecutive addresses");
   end

   // the pll window is an inclusive range, first address below last
   if (ADDR_PLL_FIRST > ADDR_PLL_LAST) begin : g_pll_range_bad
      $error("pll address range is reversed");
   end

   // the soft reset register must not alias a pad or pll address
   if ((ADDR_SOFT_RESET >= ADDR_PLL_FIRST && ADDR_SOFT_RESET <= ADDR_PLL_LAST)
       || (ADDR_SOFT_RESET >= ADDR_MASTER_DATA_OUT_PAD
           && ADDR_SOFT_RESET <= ADDR_CLOCK_OUT_PAD)) begin : g_srst_alias_bad
      $error("soft reset register overlaps another register");
   end

   // pad defaults may only use the stored bits 4:0
   if (((RST_MASTER_DATA_OUT_PAD | RST_MP6_PAD | RST_MP7_PAD | RST_CLOCK_OUT_PAD)
        & ~PAD_FIELD_MASK) != 16'h0000) begin : g_pad_default_bad
      $error("pad default sets reserved bits");
   end

   // soft reset register keeps bit 0 only
   if ((RST_SOFT_RESET & ~SRST_FIELD_MASK) != 16'h0000) begin : g_srst_default_bad
      $error("soft reset default sets reserved bits");
   end

   // the device must leave hardware reset in normal operation, not in soft reset
   if (RST_SOFT_RESET[SRST_BIT] != 1'b1) begin : g_srst_level_bad
      $error("soft reset default must be the inactive level");
   end

   // ----------------------------------------
   // soft reset level
   // ----------------------------------------
   // soft reset is held while the active-low bit is 0
   assign soft_rst = ~state_ff.srst_n;
   assign pll_hit  = (i_req.addr >= ADDR_PLL_FIRST) && (i_req.addr <= ADDR_PLL_LAST);

   // ----------------------------------------
   // pad register decode
   // ----------------------------------------
   always_comb begin
      pad_wr    = 4'h0;
      pad_wr[0] = i_req.wr && (i_req.addr == ADDR_MASTER_DATA_OUT_PAD);
      pad_wr[1] = i_req.wr && (i_req.addr == ADDR_MP6_PAD);
      pad_wr[2] = i_req.wr && (i_req.addr == ADDR_MP7_PAD);
      pad_wr[3] = i_req.wr && (i_req.addr == ADDR_CLOCK_OUT_PAD);
   end

   pcsr_pad_reg #(.RESET_VALUE(RST_MASTER_DATA_OUT_PAD)) u_master_data_out (
      .i_clock    (i_clock),
      .i_sys_rst  (i_sys_rst),
      .i_soft_rst (soft_rst),
      .i_wr       (pad_wr[0]),
      .i_wdata    (i_req.wdata),
      .o_cfg      (o_master_data_out_pad),
      .o_rdata    (pad_rdata[0])
   );

   pcsr_pad_reg #(.RESET_VALUE(RST_MP6_PAD)) u_pin_six (
      .i_clock    (i_clock),
      .i_sys_rst  (i_sys_rst),
      .i_soft_rst (soft_rst),
      .i_wr       (pad_wr[1]),
      .i_wdata    (i_req.wdata),
      .o_cfg      (o_multipurpose_pin_six_pad),
      .o_rdata    (pad_rdata[1])
   );

   pcsr_pad_reg #(.RESET_VALUE(RST_MP7_PAD)) u_pin_seven (
      .i_clock    (i_clock),
      .i_sys_rst  (i_sys_rst),
      .i_soft_rst (soft_rst),
      .i_wr       (pad_wr[2]),
      .i_wdata    (i_req.wdata),
      .o_cfg      (o_multipurpose_pin_seven_pad),
      .o_rdata    (pad_rdata[2])
   );

   pcsr_pad_reg #(.RESET_VALUE(RST_CLOCK_OUT_PAD)) u_clock_out (
      .i_clock    (i_clock),
      .i_sys_rst  (i_sys_rst),
      .i_soft_rst (soft_rst),
      .i_wr       (pad_wr[3]),
      .i_wdata    (i_req.wdata),
      .o_cfg      (o_clock_output_pin_pad),
      .o_rdata    (pad_rdata[3])
   );

   // ----------------------------------------
   // soft reset bit, slave mode and read data
   // ----------------------------------------
   always_comb begin
      nxt_state        = state_ff;
      nxt_state.rvalid = i_req.rd;
      // the soft reset register itself stays writable to leave soft reset
      if (i_req.wr && (i_req.addr == ADDR_SOFT_RESET)) begin
         nxt_state.srst_n = i_req.wdata[SRST_BIT];
      end
      // spi mode is sticky; soft reset does not touch it
      if (i_spi_select) begin
         nxt_state.mode = SLAVE_SPI;
      end
      // read mux, reads work during soft reset too
      if (i_req.rd) begin
         case (i_req.addr)
            ADDR_MASTER_DATA_OUT_PAD: nxt_state.rdata = pad_rdata[0];
            ADDR_MP6_PAD:             nxt_state.rdata = pad_rdata[1];
            ADDR_MP7_PAD:             nxt_state.rdata = pad_rdata[2];
            ADDR_CLOCK_OUT_PAD:       nxt_state.rdata = pad_rdata[3];
            ADDR_SOFT_RESET:          nxt_state.rdata = {15'h0000, state_ff.srst_n};
            default:                  nxt_state.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         // only hardware reset brings the slave port back to i2c
         state_ff <= '{srst_n: RST_SOFT_RESET[SRST_BIT], mode: SLAVE_I2C,
                       rdata: 16'h0000, rvalid: 1'b0};
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_rdata      = state_ff.rdata;
   assign o_rvalid     = state_ff.rvalid;
   assign o_slave_mode = state_ff.mode;
   assign o_soft_rst   = soft_rst;
   // pll writes pass through regardless of soft reset
   assign o_pll_wr     = i_req.wr && pll_hit;
   assign o_hit        = (i_req.wr || i_req.rd) && (|pad_wr || pll_hit
                         || (i_req.addr == ADDR_SOFT_RESET)
                         || (i_req.addr >= ADDR_MASTER_DATA_OUT_PAD
                             && i_req.addr <= ADDR_CLOCK_OUT_PAD));

endmodule : pcsr_regs

// >>> sim/pcsr_regs_properties.sv
`timescale 1ns/1ns
// ----------------------------------------
// register bank checker
// ----------------------------------------
module pcsr_regs_properties
   import pcsr_pkg::*;
(
   // clock and reset
   input wire logic              i_clock,
   input wire logic              i_sys_rst,
   // register access
   input wire pcsr_req_t         i_req,
   input wire logic [15:0]       o_rdata,
   input wire logic              o_rvalid,
   input wire logic              o_hit,
   // mode and pads
   input wire logic              i_spi_select,
   input wire pcsr_slave_mode_t  o_slave_mode,
   input wire pcsr_pad_cfg_t     o_master_data_out_pad,
   input wire pcsr_pad_cfg_t     o_multipurpose_pin_six_pad,
   input wire pcsr_pad_cfg_t     o_multipurpose_pin_seven_pad,
   input wire pcsr_pad_cfg_t     o_clock_output_pin_pad,
   input wire logic              o_soft_rst,
   input wire logic              o_pll_wr
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   property p_rd; i_req.rd |=> o_rvalid; endproperty
   a_rd: assert property (p_rd) else $error("read not answered");
   property p_srst;
      i_req.wr && i_req.addr == ADDR_SOFT_RESET |=> o_soft_rst == !$past(i_req.wdata[0]);
   endproperty
   a_srst: assert property (p_srst) else $error("soft reset level wrong");
   property p_def;
      o_soft_rst |=> o_master_data_out_pad == RST_MASTER_DATA_OUT_PAD[4:0]
         && o_multipurpose_pin_six_pad == RST_MP6_PAD[4:0]
         && o_multipurpose_pin_seven_pad == RST_MP7_PAD[4:0]
         && o_clock_output_pin_pad == RST_CLOCK_OUT_PAD[4:0];
   endproperty
   a_def: assert property (p_def) else $error("pad not at default");
   property p_pll;
      o_pll_wr == (i_req.wr && i_req.addr >= ADDR_PLL_FIRST && i_req.addr <= ADDR_PLL_LAST);
   endproperty
   a_pll: assert property (p_pll) else $error("pll write wrong");
   property p_hold; o_slave_mode == SLAVE_SPI |=> o_slave_mode == SLAVE_SPI; endproperty
   a_hold: assert property (p_hold) else $error("spi mode lost");
   property p_sel; i_spi_select |=> o_slave_mode == SLAVE_SPI; endproperty
   a_sel: assert property (p_sel) else $error("spi not selected");
   property p_wr6;
      i_req.wr && i_req.addr == ADDR_MP6_PAD && !o_soft_rst
         |=> o_multipurpose_pin_six_pad == $past(i_req.wdata[4:0]);
   endproperty
   a_wr6: assert property (p_wr6) else $error("pin six pad write lost");
   property p_unk; o_rvalid && !$past(o_hit) |-> o_rdata == 16'h0000; endproperty
   a_unk: assert property (p_unk) else $error("unmapped read not zero");
   c_srst: cover property (o_soft_rst);
   c_spi: cover property (o_slave_mode == SLAVE_SPI && o_soft_rst);
   c_unk: cover property (o_rvalid && !$past(o_hit));
endmodule : pcsr_regs_properties

bind pcsr_regs pcsr_regs_properties i_chk (.*);

// >>> sim/pcsr_host.sv
`timescale 1ns/1ns
// host on the slave control port, one-cycle strobes
module pcsr_host
   import pcsr_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_rvalid,
   input  wire logic [15:0] i_rdata,
   output pcsr_req_t        o_req
);
   initial o_req = '0;
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_clock);
      o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge i_clock);
      o_req <= '0;
   endtask : wr
   // bounded wait for the answer pulse
   task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
      ok = 1'b0;
      d = 16'h0000;
      @(posedge i_clock);
      o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge i_clock);
      o_req <= '0;
      for (int i = 0; i < 4 && !ok; i++) begin
         @(posedge i_clock);
         if (i_rvalid === 1'b1) begin
            ok = 1'b1;
            d = i_rdata;
         end
      end
   endtask : rd
endmodule : pcsr_host

// >>> sim/pcsr_regs_tb.sv
`timescale 1ns/1ns
module pcsr_regs_tb
   import pcsr_pkg::*;
;
   localparam logic [15:0] ADR [4] = '{ADDR_MASTER_DATA_OUT_PAD, ADDR_MP6_PAD, ADDR_MP7_PAD,
                                       ADDR_CLOCK_OUT_PAD};
   localparam logic [15:0] RSV [4] = '{RST_MASTER_DATA_OUT_PAD, RST_MP6_PAD, RST_MP7_PAD,
                                       RST_CLOCK_OUT_PAD};
   logic i_clock = 1'b0, i_sys_rst = 1'b1, i_spi_select = 1'b0, o_rvalid, o_hit, o_soft_rst;
   logic [15:0]      o_rdata, wv;
   pcsr_req_t        req;
   pcsr_slave_mode_t md;
   pcsr_pad_cfg_t    pad [4];
   int               num_errors = 0, cmp_count = 0;
   int               pll_cnt = 0, miss_cnt = 0;
   logic             pll_wr;
   initial forever #2 i_clock = ~i_clock;
   pcsr_host i_host (.i_clock(i_clock), .i_rvalid(o_rvalid), .i_rdata(o_rdata), .o_req(req));
   pcsr_regs i_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_req(req), .o_rdata(o_rdata),
      .o_rvalid(o_rvalid), .o_hit(o_hit), .i_spi_select(i_spi_select), .o_slave_mode(md),
      .o_master_data_out_pad(pad[0]), .o_multipurpose_pin_six_pad(pad[1]),
      .o_multipurpose_pin_seven_pad(pad[2]), .o_clock_output_pin_pad(pad[3]),
      .o_soft_rst(o_soft_rst), .o_pll_wr(pll_wr));
   // count pll write strobes and requests that hit no register
   always @(posedge i_clock) begin
      if (pll_wr === 1'b1) pll_cnt <= pll_cnt + 1;
      if ((req.wr || req.rd) && o_hit !== 1'b1) miss_cnt <= miss_cnt + 1;
   end
   task automatic give_verdict();
      if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch at %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic rchk(input logic [15:0] a, input logic [15:0] e);
      logic [15:0] d;
      logic        ok;
      i_host.rd(a, d, ok);
      if (!ok) begin
         num_errors++;
         $display("mismatch at %0t: read not answered", $time);
         give_verdict();
      end else chk(d, e);
   endtask : rchk
   // main sequence
   initial begin
      repeat (3) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         chk({11'h0, pad[i]}, RSV[i]);
         rchk(ADR[i], RSV[i]);
         wv = {11'h7FF, 1'b1, 2'(i), ~2'(i)};
         i_host.wr(ADR[i], wv);
         #1 chk({11'h0, pad[i]}, wv & PAD_FIELD_MASK);
         rchk(ADR[i], wv & PAD_FIELD_MASK);
      end
      rchk(ADDR_SOFT_RESET, RST_SOFT_RESET);
      rchk(16'hF7A4, 16'h0000);
      i_host.wr(ADDR_MP6_PAD, 16'h0003);
      rchk(ADDR_MP6_PAD, 16'h0003);
      @(posedge i_clock) i_spi_select <= 1'b1;
      @(posedge i_clock) i_spi_select <= 1'b0;
      #1 chk({14'h0, md}, {14'h0, SLAVE_SPI});
      i_host.wr(ADDR_SOFT_RESET, 16'hFFFE);
      #1 chk({15'h0, o_soft_rst}, 16'h0001);
      rchk(ADDR_SOFT_RESET, 16'h0000);
      i_host.wr(ADR[1], 16'h001F);
      i_host.wr(ADDR_PLL_LAST, 16'h1234);
      #1 chk(16'(pll_cnt), 16'h0001);
      for (int i = 0; i < 4; i++) chk({11'h0, pad[i]}, RSV[i]);
      chk({14'h0, md}, {14'h0, SLAVE_SPI});
      i_host.wr(ADDR_SOFT_RESET, 16'h0001);
      #1 chk({15'h0, o_soft_rst}, 16'h0000);
      i_host.wr(ADR[3], 16'h0013);
      rchk(ADR[3], 16'h0013);
      @(posedge i_clock) i_sys_rst <= 1'b1;
      repeat (3) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      #1 chk({14'h0, md}, {14'h0, SLAVE_I2C});
      chk({11'h0, pad[3]}, RST_CLOCK_OUT_PAD);
      rchk(ADDR_SOFT_RESET, RST_SOFT_RESET);
      chk(16'(miss_cnt), 16'h0001);
      give_verdict();
   end
endmodule : pcsr_regs_tb
